// [rtl/ddpc_mode_pin_ctrl.sv]
// top of the mode and shared-pin control block: strap decode, shared-pin routing,
// sample capture, format conversion, retime phase, aux routing and register bus
// assumes every pin input is asynchronous to i_clk and changes slower than i_clk
// Overview of operation
// - strap low selects serial-register mode
// - strap high selects direct pin mode
// - strap high pulse resets serial registers
// - shared clock pin clocks serial port
// - shared data pin is bidirectional serial data
// - transactions only while select held low
// - rising pin edge picks retime phase
// - format pin: low binary, high twos
// - power-down pin stops core updates only
// - internal set resistor repurposes adjust pin
// - samples captured on data qualify clock
//
// Implementation choices: strobed register access and the placing of the registers.
module ddpc_mode_pin_ctrl
    import ddpc_pkg::*;
#(
    parameter int unsigned DW = SAMPLE_W
) (
    input wire logic i_clk,                              // system clock, 10 MHz
    input wire logic i_rst_n,                            // async reset, active low
    input wire logic i_pin_config_mode,                  // mode strap and reset pin
    input wire logic i_retime_phase_select,              // serial clock / retime pin
    input wire logic i_shared_data,                      // serial data / format pin in
    output logic o_shared_data,                          // serial data pin out
    output logic o_shared_data_oe,                       // serial data pin drive enable
    input wire logic i_power_down_pin,                   // chip select / power-down pin
    input wire logic i_data_qualify_clock,               // input data clock pin
    input wire logic i_sampling_clock_in,                // sampling clock pin
    input wire logic [DW-1:0] i_sample_data,             // parallel sample word pins
    output logic [DW-1:0] o_core_sample,                 // offset binary word to core
    output logic o_core_update,                          // pulse, new core word
    output logic o_power_down,                           // core powered down
    output logic o_twos_complement,                      // active input format
    output logic o_retime_phase,                         // chosen retime clock phase
    output logic o_fullscale_adjust_first_aux_en,        // first adjust pin is aux output
    output logic [SPI_DATA_W-1:0] o_aux_out_first_channel,   // first aux code
    output logic o_fullscale_adjust_second_aux_en,       // second adjust pin is aux output
    output logic [SPI_DATA_W-1:0] o_aux_out_second_channel,  // second aux code
    input wire logic [REG_ADDR_W-1:0] i_reg_addr,        // register byte address
    input wire logic [REG_DATA_W-1:0] i_reg_wdata,       // register write data
    input wire logic i_reg_wr,                           // register write strobe
    input wire logic i_reg_rd,                           // register read strobe
    output logic [REG_DATA_W-1:0] o_reg_rdata            // read data, cycle after strobe
);
    localparam logic [DW-1:0] MSB_MASK = {1'b1, {(DW-1){1'b0}}};

    // pin synchronisers and edge history
    logic [PIN_NUM-1:0] pin_s1_q, pin_s1_d;
    logic [PIN_NUM-1:0] pin_s2_q, pin_s2_d;
    logic [PIN_NUM-1:0] pin_prev_q, pin_prev_d;
    logic [DW-1:0] dat_s1_q, dat_s1_d;
    logic [DW-1:0] dat_s2_q, dat_s2_d;

    // datapath state
    logic [DW-1:0] cap_q, cap_d;
    logic [DW-1:0] core_q, core_d;
    logic upd_q, upd_d;
    logic power_down_pin_q, power_down_pin_d;
    logic twos_q, twos_d;
    logic phase_q, phase_d;
    logic aux1_en_q, aux1_en_d;
    logic aux2_en_q, aux2_en_d;
    logic [SPI_DATA_W-1:0] aux1_q, aux1_d;
    logic [SPI_DATA_W-1:0] aux2_q, aux2_d;

    // register bus state
    logic [REG_DATA_W-1:0] ctrl_q, ctrl_d;
    logic [REG_DATA_W-1:0] rdata_q, rdata_d;

    // decoded pin levels and edges
    logic pin_mode;
    logic sclk_rise;
    logic sclk_fall;
    logic clk_rise;
    logic dq_rise;
    logic smp_rise;
    logic [CFG_NREG*SPI_DATA_W-1:0] cfg_flat;
    logic [SPI_DATA_W-1:0] cfg_ctrl;
    logic spi_sdo;
    logic spi_oe;
    logic spi_sdo_q;
    logic spi_oe_q;

    // two-flop synchronisers, second stage feeds the edge history
    always_comb begin
        pin_s1_d = {i_sampling_clock_in, i_data_qualify_clock, i_power_down_pin,
                    i_shared_data, i_retime_phase_select, i_pin_config_mode};
        pin_s2_d = pin_s1_q;
        pin_prev_d = pin_s2_q;
        dat_s1_d = i_sample_data;
        dat_s2_d = dat_s1_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_prev_q <= '0;
            dat_s1_q <= '0;
            dat_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_prev_q <= pin_prev_d;
            dat_s1_q <= dat_s1_d;
            dat_s2_q <= dat_s2_d;
        end
    end

    assign pin_mode = pin_s2_q[PIN_MODE];
    // serial clock edges exist only in serial mode
    assign sclk_rise = !pin_mode && pin_s2_q[PIN_CLK] && !pin_prev_q[PIN_CLK];
    assign sclk_fall = !pin_mode && !pin_s2_q[PIN_CLK] && pin_prev_q[PIN_CLK];
    // retime trigger only in pin mode
    assign clk_rise = pin_mode && pin_s2_q[PIN_CLK] && !pin_prev_q[PIN_CLK];
    assign dq_rise = pin_s2_q[PIN_DQCLK] && !pin_prev_q[PIN_DQCLK];
    assign smp_rise = pin_s2_q[PIN_SMPCLK] && !pin_prev_q[PIN_SMPCLK];
    assign cfg_ctrl = cfg_flat[CFG_CTRL*SPI_DATA_W +: SPI_DATA_W];

    // serial port on the shared pins, reset by the strap pulse
    ddpc_serial_port #(
        .NREG(CFG_NREG)
    ) u_serial_port (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_enable(!pin_mode),
        .i_cfg_reset(pin_mode),
        .i_csn(pin_s2_q[PIN_SEL]),
        .i_sclk_rise(sclk_rise),
        .i_sclk_fall(sclk_fall),
        .i_sdi(pin_s2_q[PIN_DATA]),
        .o_sdo(spi_sdo),
        .o_sdo_oe(spi_oe),
        .o_cfg(cfg_flat)
    );

    // mode routing, sample capture and core update
    always_comb begin
        cap_d = cap_q;
        core_d = core_q;
        upd_d = 1'b0;
        phase_d = phase_q;
        // format from pin in pin mode, from serial register otherwise
        twos_d = pin_mode ? pin_s2_q[PIN_DATA] : cfg_ctrl[CFG_TWOS_BIT];
        // power-down from pin in pin mode
        power_down_pin_d = pin_mode ? pin_s2_q[PIN_SEL] : cfg_ctrl[CFG_POWER_DOWN_PIN_BIT];
        // phase only moves on a rising retime pin edge
        if (clk_rise) begin
            phase_d = pin_s2_q[PIN_SMPCLK];
        end
        if (dq_rise) begin
            cap_d = twos_q ? (dat_s2_q ^ MSB_MASK) : dat_s2_q;
        end
        if (smp_rise && !power_down_pin_q && ctrl_q[CTRL_CORE_EN_BIT]) begin
            core_d = cap_q;
            upd_d = 1'b1;
        end
        // adjust pins become aux outputs with internal set resistor
        aux1_en_d = cfg_ctrl[CFG_RSET_FIRST_BIT];
        aux2_en_d = cfg_ctrl[CFG_RSET_SECOND_BIT];
        aux1_d = aux1_en_d ? cfg_flat[CFG_AUX_FIRST*SPI_DATA_W +: SPI_DATA_W] : '0;
        aux2_d = aux2_en_d ? cfg_flat[CFG_AUX_SECOND*SPI_DATA_W +: SPI_DATA_W] : '0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_q <= '0;
            core_q <= '0;
            upd_q <= 1'b0;
            power_down_pin_q <= 1'b0;
            twos_q <= 1'b0;
            phase_q <= 1'b0;
            aux1_en_q <= 1'b0;
            aux2_en_q <= 1'b0;
            aux1_q <= '0;
            aux2_q <= '0;
        end else begin
            cap_q <= cap_d;
            core_q <= core_d;
            upd_q <= upd_d;
            power_down_pin_q <= power_down_pin_d;
            twos_q <= twos_d;
            phase_q <= phase_d;
            aux1_en_q <= aux1_en_d;
            aux2_en_q <= aux2_en_d;
            aux1_q <= aux1_d;
            aux2_q <= aux2_d;
        end
    end

    // software register bus: control write, status and sample readback
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = '0;
        if (i_reg_wr && i_reg_addr == OFS_CTRL) begin
            ctrl_d = i_reg_wdata;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                OFS_CTRL: rdata_d = ctrl_q;
                OFS_STATUS: begin
                    rdata_d[ST_PIN_MODE_BIT] = pin_mode;
                    rdata_d[ST_POWER_DOWN_PIN_BIT] = power_down_pin_q;
                    rdata_d[ST_TWOS_BIT] = twos_q;
                    rdata_d[ST_PHASE_BIT] = phase_q;
                    rdata_d[ST_RSET_FIRST_BIT] = aux1_en_q;
                    rdata_d[ST_RSET_SECOND_BIT] = aux2_en_q;
                end
                OFS_SAMPLE: rdata_d = REG_DATA_W'(core_q);
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RST;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // serial data pin output taken from port flops
    assign spi_sdo_q = spi_sdo;
    assign spi_oe_q = spi_oe;

    assign o_shared_data = spi_sdo_q;
    assign o_shared_data_oe = spi_oe_q;
    assign o_core_sample = core_q;
    assign o_core_update = upd_q;
    assign o_power_down = power_down_pin_q;
    assign o_twos_complement = twos_q;
    assign o_retime_phase = phase_q;
    assign o_fullscale_adjust_first_aux_en = aux1_en_q;
    assign o_fullscale_adjust_second_aux_en = aux2_en_q;
    assign o_aux_out_first_channel = aux1_q;
    assign o_aux_out_second_channel = aux2_q;
    assign o_reg_rdata = rdata_q;

    // checks on the mode routing, all in the system clock domain
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_serial_format: assert property (
        !pin_mode |=> o_twos_complement == $past(cfg_ctrl[CFG_TWOS_BIT]))
        else $error("serial mode format not taken from register");
    chk_pin_format: assert property (
        pin_mode |=> o_twos_complement == $past(pin_s2_q[PIN_DATA]))
        else $error("pin mode format not taken from pin");
    chk_pin_no_serial: assert property (
        pin_mode [*2] |-> !o_shared_data_oe)
        else $error("data pin driven in pin mode");
    chk_pin_powerdown: assert property (
        pin_mode && pin_s2_q[PIN_SEL] |=> o_power_down ##1 !o_core_update)
        else $error("core updated while powered down");
    chk_phase_fixed: assert property (
        !clk_rise |=> $stable(o_retime_phase))
        else $error("retime phase moved without an edge");
    chk_phase_edge: assert property (
        clk_rise |=> o_retime_phase == $past(pin_s2_q[PIN_SMPCLK]))
        else $error("retime phase not latched on edge");
    chk_capture_dqclk: assert property (
        !dq_rise |=> $stable(cap_q))
        else $error("capture without data qualify edge");
    chk_twos_msb: assert property (
        dq_rise && twos_q |=> cap_q[DW-1] == !$past(dat_s2_q[DW-1]))
        else $error("msb not inverted for twos complement");
    chk_aux_route: assert property (
        !cfg_ctrl[CFG_RSET_FIRST_BIT] |=> !o_fullscale_adjust_first_aux_en
        && o_aux_out_first_channel == '0)
        else $error("aux output active without internal set resistor");
    chk_strap_reset: assert property (
        pin_mode |=> cfg_flat == '0)
        else $error("serial registers kept while strap high");
    // update strobe lasts one cycle only
    chk_update_pulse: assert property (
        o_core_update |=> !o_core_update)
        else $error("core update pulse too long");
    // core word moves only with its strobe
    chk_core_hold: assert property (
        !o_core_update |-> $stable(o_core_sample))
        else $error("core word changed without update");
    // serial mode power-down from register
    chk_serial_power_down_pin: assert property (
        !pin_mode |=> o_power_down == $past(cfg_ctrl[CFG_POWER_DOWN_PIN_BIT]))
        else $error("serial mode power-down not from register");
    // second adjust pin follows its enable
    chk_aux_second: assert property (
        !cfg_ctrl[CFG_RSET_SECOND_BIT] |=> !o_fullscale_adjust_second_aux_en
        && o_aux_out_second_channel == '0)
        else $error("second aux output active without set resistor");
endmodule

// [shared/ddpc_pkg.sv]
// constants shared by the mode and shared-pin control block and its serial port
// assumes one 10 MHz system clock; all pins arrive asynchronously
package ddpc_pkg;
    // system clock
    localparam int unsigned CLK_PERIOD_NS = 100;
    // software register bus
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SAMPLE = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int unsigned CTRL_CORE_EN_BIT = 0;
    localparam int unsigned ST_PIN_MODE_BIT = 0;
    localparam int unsigned ST_POWER_DOWN_PIN_BIT = 1;
    localparam int unsigned ST_TWOS_BIT = 2;
    localparam int unsigned ST_PHASE_BIT = 3;
    localparam int unsigned ST_RSET_FIRST_BIT = 4;
    localparam int unsigned ST_RSET_SECOND_BIT = 5;
    // positions of the control pins in the synchroniser vector
    localparam int unsigned PIN_MODE = 0;
    localparam int unsigned PIN_CLK = 1;
    localparam int unsigned PIN_DATA = 2;
    localparam int unsigned PIN_SEL = 3;
    localparam int unsigned PIN_DQCLK = 4;
    localparam int unsigned PIN_SMPCLK = 5;
    localparam int unsigned PIN_NUM = 6;
    // serial frame: one command byte (read flag, address) then one data byte
    localparam int unsigned SPI_DATA_W = 8;
    localparam int unsigned SPI_ADDR_W = 7;
    localparam int unsigned SPI_RW_BIT = 7;
    localparam logic [2:0] SPI_BIT_LAST = 3'h7;
    // serial configuration registers
    localparam int unsigned CFG_NREG = 4;
    localparam int unsigned CFG_CTRL = 0;
    localparam int unsigned CFG_AUX_FIRST = 1;
    localparam int unsigned CFG_AUX_SECOND = 2;
    localparam int unsigned CFG_POWER_DOWN_PIN_BIT = 0;
    localparam int unsigned CFG_TWOS_BIT = 1;
    localparam int unsigned CFG_RSET_FIRST_BIT = 2;
    localparam int unsigned CFG_RSET_SECOND_BIT = 3;
    localparam logic [7:0] CFG_DEF_REG = 8'h00;
    // sample word width
    localparam int unsigned SAMPLE_W = 14;
endpackage

// [rtl/ddpc_serial_port.sv]
// serial configuration port: shift engine and configuration register array
// assumes synchronised select and data, and one-cycle serial clock edge pulses
module ddpc_serial_port
    import ddpc_pkg::*;
#(
    parameter int unsigned NREG = CFG_NREG
) (
    input wire logic i_clk,                          // system clock
    input wire logic i_rst_n,                        // async reset, active low
    input wire logic i_enable,                       // serial-register mode active
    input wire logic i_cfg_reset,                    // return registers to defaults
    input wire logic i_csn,                          // synchronised chip select, low active
    input wire logic i_sclk_rise,                    // serial clock rising edge pulse
    input wire logic i_sclk_fall,                    // serial clock falling edge pulse
    input wire logic i_sdi,                          // synchronised serial data in
    output logic o_sdo,                              // serial data out
    output logic o_sdo_oe,                           // data line drive enable
    output logic [NREG*SPI_DATA_W-1:0] o_cfg         // configuration registers, flat
);
    localparam int unsigned AW = $clog2(NREG);
    localparam logic [SPI_ADDR_W-1:0] NREG_A = SPI_ADDR_W'(NREG);

    typedef enum logic [1:0] {SP_CMD, SP_DATA, SP_DONE} ddpc_sp_state_t;

    ddpc_sp_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [SPI_DATA_W-1:0] shift_q, shift_d;
    logic [SPI_DATA_W-1:0] out_q, out_d;
    logic [SPI_ADDR_W-1:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic [SPI_DATA_W-1:0] cfg_q [NREG];
    logic [SPI_DATA_W-1:0] cfg_d [NREG];

    // frame sequencing, readback and register writes
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        out_d = out_q;
        addr_d = addr_q;
        rd_d = rd_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        cfg_d = cfg_q;
        if (!i_enable || i_csn) begin
            state_d = SP_CMD;
            cnt_d = '0;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                SP_CMD: begin
                    if (i_sclk_rise) begin
                        shift_d = {shift_q[SPI_DATA_W-2:0], i_sdi};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == SPI_BIT_LAST) begin
                            rd_d = shift_d[SPI_RW_BIT];
                            addr_d = shift_d[SPI_ADDR_W-1:0];
                            out_d = (shift_d[SPI_ADDR_W-1:0] < NREG_A) ?
                                cfg_q[shift_d[AW-1:0]] : '0;
                            state_d = SP_DATA;
                        end
                    end
                end
                SP_DATA: begin
                    if (i_sclk_fall && rd_q) begin
                        oe_d = 1'b1;
                        sdo_d = out_q[SPI_DATA_W-1];
                        out_d = {out_q[SPI_DATA_W-2:0], 1'b0};
                    end
                    if (i_sclk_rise) begin
                        shift_d = {shift_q[SPI_DATA_W-2:0], i_sdi};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == SPI_BIT_LAST) begin
                            if (!rd_q && addr_q < NREG_A) begin
                                cfg_d[addr_q[AW-1:0]] = shift_d;
                            end
                            state_d = SP_DONE;
                        end
                    end
                end
                SP_DONE: begin
                    if (i_sclk_fall) begin
                        oe_d = 1'b0;
                    end
                end
                default: state_d = SP_CMD;
            endcase
        end
        if (i_cfg_reset) begin
            for (int i = 0; i < NREG; i++) begin
                cfg_d[i] = CFG_DEF_REG;
            end
        end
    end

    // serial port state registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= SP_CMD;
            cnt_q <= '0;
            shift_q <= '0;
            out_q <= '0;
            addr_q <= '0;
            rd_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            for (int i = 0; i < NREG; i++) begin
                cfg_q[i] <= CFG_DEF_REG;
            end
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            out_q <= out_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            cfg_q <= cfg_d;
        end
    end

    // flatten the register array for the mode logic
    for (genvar gi = 0; gi < NREG; gi++) begin : g_cfg
        assign o_cfg[gi*SPI_DATA_W +: SPI_DATA_W] = cfg_q[gi];
    end

    assign o_sdo = sdo_q;
    assign o_sdo_oe = oe_q;

    chk_cfg_defaults: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cfg_reset |=> o_cfg == {NREG{CFG_DEF_REG}})
        else $error("config registers not at defaults after reset pulse");
    chk_deselect_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_csn || !i_enable) && !i_cfg_reset |=> $stable(o_cfg) && !o_sdo_oe)
        else $error("serial port acted while deselected");
    chk_drive_on_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_sdo_oe) |-> rd_q && $past(i_sclk_fall))
        else $error("data line driven outside a read");
    chk_sclk_paces: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_sclk_rise && !i_csn && i_enable |=> $stable(cnt_q))
        else $error("bit counter moved without a serial clock edge");
endmodule

// [bench/ddpc_host_model.sv]
// host model: strap, shared pins, clocks and sample word
// assumes the bench merges the data line using the device drive enable
module ddpc_host_model
    import ddpc_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_line, // merged data line
    output logic o_mode, // strap
    output logic o_sclk, // serial clock, retime
    output logic o_sdata, // data, format
    output logic o_csn, // select, power-down
    output logic o_dqclk, // qualify clock
    output logic o_smpclk, // sampling clock
    output logic [SAMPLE_W-1:0] o_word // sample word
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle levels, select high
    initial {o_mode, o_sclk, o_sdata, o_csn, o_dqclk, o_smpclk, o_word} = {3'h0, 1'b1, 16'h0};
    task automatic set_pins(input logic m, input logic f, input logic p);
        o_mode <= m;
        o_sdata <= f;
        o_csn <= p;
        repeat (8) @(posedge i_clk);
    endtask
    // framed transfer, line toggles once released
    task automatic spi(input logic r, input logic [6:0] a, input logic [7:0] d,
            input logic en, output logic [7:0] q);
        logic [15:0] f;
        f = {r, a, d};
        q = 8'h00;
        o_csn <= ~en;
        repeat (4) @(posedge i_clk);
        for (int i = 15; i >= 0; i--) begin
            o_sdata <= (r && i < 8) ? ~o_sdata : f[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            if (i < 8) q[i] = i_line;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_csn <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask
    // word, qualify edge, then sampling edge; word stale afterwards
    task automatic capture(input logic [SAMPLE_W-1:0] d);
        o_word <= d;
        repeat (4) @(posedge i_clk);
        o_dqclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_dqclk <= 1'b0;
        o_smpclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_word <= ~d;
        o_smpclk <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
    // sampling level, then retime edge if asked
    task automatic retime(input logic lvl, input logic rise);
        o_smpclk <= lvl;
        repeat (4) @(posedge i_clk);
        o_sclk <= rise;
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// [bench/test_dual_dac_mode_pin_control.sv]
// bench: host model on the pins, register bus driven here
// assumes a pin-to-output latency of a few system clocks
module test_dual_dac_mode_pin_control
    import ddpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, i_pin_config_mode, i_retime_phase_select, host_sd;
    logic i_shared_data, o_shared_data, o_shared_data_oe, i_power_down_pin;
    logic i_data_qualify_clock, i_sampling_clock_in, o_core_update, o_power_down;
    logic o_twos_complement, o_retime_phase, i_reg_wr, i_reg_rd;
    logic o_fullscale_adjust_first_aux_en, o_fullscale_adjust_second_aux_en;
    logic [SAMPLE_W-1:0] i_sample_data, o_core_sample;
    logic [SPI_DATA_W-1:0] o_aux_out_first_channel, o_aux_out_second_channel, q8;
    logic [REG_ADDR_W-1:0] i_reg_addr;
    logic [REG_DATA_W-1:0] i_reg_wdata, o_reg_rdata, q;
    int errors = 0, samples_checked = 0, cycles = 0, updates = 0;
    // data line: device wins while it drives
    assign i_shared_data = o_shared_data_oe ? o_shared_data : host_sd;
    ddpc_mode_pin_ctrl ddpc_mode_pin_ctrl_i (
        .i_clk, .i_rst_n, .i_pin_config_mode, .i_retime_phase_select, .i_shared_data,
        .o_shared_data, .o_shared_data_oe, .i_power_down_pin, .i_data_qualify_clock,
        .i_sampling_clock_in, .i_sample_data, .o_core_sample, .o_core_update,
        .o_power_down, .o_twos_complement, .o_retime_phase, .o_fullscale_adjust_first_aux_en,
        .o_aux_out_first_channel, .o_fullscale_adjust_second_aux_en,
        .o_aux_out_second_channel, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata
    );
    ddpc_host_model ddpc_host_model_i (
        .i_clk, .i_line(i_shared_data), .o_mode(i_pin_config_mode),
        .o_sclk(i_retime_phase_select), .o_sdata(host_sd), .o_csn(i_power_down_pin),
        .o_dqclk(i_data_qualify_clock), .o_smpclk(i_sampling_clock_in), .o_word(i_sample_data)
    );
    // clock and hang guard
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (o_core_update) updates++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("mismatches %0d, checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("BAD at %0t: saw %h, wanted %h", $time, s, e);
        end
    endtask
    // register bus cycles
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 q = o_reg_rdata;
    endtask
    task automatic t_reset();
        reg_rd(OFS_CTRL);
        check(q, CTRL_RST);
        reg_wr(OFS_STATUS, 32'hFFFF_FFFF);
        reg_rd(OFS_STATUS);
        check(q, 32'h0);
        reg_rd(8'h0C);
        check(q, 32'h0);
    endtask
    task automatic t_serial();
        ddpc_host_model_i.spi(1'b0, 7'h00, 8'h04, 1'b1, q8);
        ddpc_host_model_i.spi(1'b0, 7'h01, 8'hA5, 1'b1, q8);
        check(32'(o_fullscale_adjust_first_aux_en), 32'h1);
        check(32'(o_aux_out_first_channel), 32'hA5);
        ddpc_host_model_i.spi(1'b1, 7'h01, 8'h00, 1'b1, q8);
        check(32'(q8), 32'hA5);
        check(32'(o_shared_data_oe), 32'h0);
        ddpc_host_model_i.spi(1'b0, 7'h00, 8'h0B, 1'b1, q8);
        check(32'(o_aux_out_first_channel), 32'h0);
        reg_rd(OFS_STATUS);
        check(q, 32'h26);
        ddpc_host_model_i.spi(1'b0, 7'h02, 8'h3C, 1'b1, q8);
        check(32'(o_aux_out_second_channel), 32'h3C);
        ddpc_host_model_i.spi(1'b0, 7'h00, 8'h04, 1'b0, q8);
        check(32'(o_power_down), 32'h1);
    endtask
    task automatic t_strap();
        ddpc_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
        ddpc_host_model_i.set_pins(1'b0, 1'b0, 1'b1);
        check(32'(o_power_down), 32'h0);
        check(32'(o_fullscale_adjust_second_aux_en), 32'h0);
        check(32'(o_aux_out_second_channel), 32'h0);
        ddpc_host_model_i.spi(1'b1, 7'h01, 8'h00, 1'b1, q8);
        check(32'(q8), 32'h0);
    endtask
    task automatic t_pin();
        ddpc_host_model_i.set_pins(1'b1, 1'b1, 1'b0);
        ddpc_host_model_i.capture(14'h0123);
        check(32'(o_core_sample), 32'h2123);
        check(updates, 1);
        check(32'(o_twos_complement), 32'h1);
        ddpc_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
        ddpc_host_model_i.capture(14'h2ABC);
        reg_rd(OFS_SAMPLE);
        check(q, 32'h2ABC);
        reg_wr(OFS_CTRL, 32'h0);
        ddpc_host_model_i.capture(14'h1111);
        check(updates, 2);
        reg_wr(OFS_CTRL, CTRL_RST);
        ddpc_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
        ddpc_host_model_i.capture(14'h0001);
        check(32'(o_core_sample), 32'h2ABC);
        check(updates, 2);
        reg_rd(OFS_STATUS);
        check(q, 32'h3);
        ddpc_host_model_i.retime(1'b1, 1'b1);
        check(32'(o_retime_phase), 32'h1);
        ddpc_host_model_i.retime(1'b0, 1'b0);
        check(32'(o_retime_phase), 32'h1);
        ddpc_host_model_i.retime(1'b0, 1'b1);
        check(32'(o_retime_phase), 32'h0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        i_rst_n = 1'b0;
        {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_serial();
        t_strap();
        t_pin();
        close_out();
    end
endmodule
